/* bench/dev_side_model.sv */
/*
 Device-side engine model: supplies PIO read words.
 Assumes one clock shared with the register bank.
*/
`timescale 1ns/1ps
module dev_side_model (
   input  wire        clock,
   input  wire        reset_n,
   output reg  [15:0] dev_rdata
);
   // The word steps every cycle, so a half sampled on the wrong edge shows up.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         dev_rdata <= 16'h1000;
      else
         dev_rdata <= dev_rdata + 16'h0001;
   end
endmodule

/* bench/taskfile_properties.sv */
/*
 Port assertions for the taskfile register bank.
 Assumes it is bound to the bank top module.
*/
`timescale 1ns/1ps
module taskfile_checker (
   input wire        clock,
   input wire        reset_n,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [7:0]  reg_addr,
   input wire        reg_wide,
   input wire [31:0] reg_wdata,
   input wire [31:0] reg_rdata_r,
   input wire        reg_rvalid_r,
   input wire [1:0]  addr_mode,
   input wire [7:0]  dev_error,
   input wire [7:0]  dev_status,
   input wire        phy_ready_evt,
   input wire        phy_change_evt,
   input wire        pio_valid_r,
   input wire        pio_write_r,
   input wire [15:0] pio_wdata_r,
   input wire        pio_read_r,
   input wire        cmd_start_r,
   input wire [7:0]  cmd_code_r,
   input wire [15:0] cmd_count_r,
   input wire        phy_ready_int_r,
   input wire        phy_change_int_r
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_count_read_answer: assert property (
      reg_rd && reg_addr == 8'h08 |=> reg_rvalid_r) else $error("count read not answered");
   a_error_read_gated: assert property (
      reg_rd && reg_addr == 8'h04 |=> reg_rvalid_r && reg_rdata_r ==
      ($past(dev_status[0]) ? {24'h0, $past(dev_error)} : 32'h0)) else $error("bad error read");
   a_cmd_launch: assert property (
      reg_wr && reg_addr == 8'h1c |=> cmd_start_r && cmd_code_r == $past(reg_wdata[7:0]))
      else $error("command not launched");
   a_count_low_byte: assert property (
      cmd_start_r && $past(addr_mode) != 2'h2 |-> cmd_count_r[15:8] == 8'h00)
      else $error("count high byte used");
   a_ready_int_gate: assert property (
      phy_ready_int_r |-> $past(phy_ready_evt)) else $error("ready interrupt without event");
   a_change_int_gate: assert property (
      phy_change_int_r |-> $past(phy_change_evt)) else $error("change interrupt without event");
   a_narrow_write: assert property (
      reg_wr && reg_addr == 8'h00 && !reg_wide |-> ##2 pio_valid_r && pio_write_r &&
      pio_wdata_r == $past(reg_wdata[15:0], 2) ##1 !pio_valid_r) else $error("bad 16-bit write");
   a_wide_split: assert property (
      reg_wr && reg_addr == 8'h00 && reg_wide |-> ##2 pio_valid_r &&
      pio_wdata_r == $past(reg_wdata[15:0], 2) ##1 pio_valid_r &&
      pio_wdata_r == $past(reg_wdata[31:16], 3)) else $error("bad 32-bit split");
   a_narrow_read: assert property (
      reg_rd && reg_addr == 8'h00 && !reg_wide |-> ##2 pio_read_r && pio_valid_r &&
      !pio_write_r && reg_rvalid_r ##1 !pio_read_r) else $error("bad 16-bit read");
   a_wide_read: assert property (
      reg_rd && reg_addr == 8'h00 && reg_wide |-> ##2 pio_read_r && !reg_rvalid_r ##1
      pio_read_r && reg_rvalid_r) else $error("bad 32-bit read");
endmodule
bind sata_port_taskfile_regs taskfile_checker chk_u (.clock(clock), .reset_n(reset_n),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wide(reg_wide),
   .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
   .addr_mode(addr_mode), .dev_error(dev_error), .dev_status(dev_status),
   .phy_ready_evt(phy_ready_evt), .phy_change_evt(phy_change_evt),
   .pio_valid_r(pio_valid_r), .pio_write_r(pio_write_r), .pio_wdata_r(pio_wdata_r),
   .pio_read_r(pio_read_r),
   .cmd_start_r(cmd_start_r), .cmd_code_r(cmd_code_r), .cmd_count_r(cmd_count_r),
   .phy_ready_int_r(phy_ready_int_r), .phy_change_int_r(phy_change_int_r));

/* bench/tb.sv */
/*
 Self-checking bench for the taskfile register bank.
 Assumes the device-side model and the bound checker.
*/
`timescale 1ns/1ps
module tb;
   reg         clock, reset_n, reg_wr, reg_rd, reg_wide, evt;
   reg  [7:0]  reg_addr, dev_status, dev_error;
   reg  [31:0] reg_wdata, q;
   reg  [1:0]  addr_mode;
   reg  [15:0] w;
   wire [31:0] reg_rdata_r;
   wire [15:0] dev_rdata, feat, cnt, sect;
   wire        reg_rvalid_r, cmd_start_r, rdy_int, chg_int;
   integer     err_count, n_compared, i;
   dev_side_model pm_u (.clock(clock), .reset_n(reset_n), .dev_rdata(dev_rdata));
   sata_port_taskfile_regs dut_u (.clock(clock), .reset_n(reset_n), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wide(reg_wide), .reg_wdata(reg_wdata),
      .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .addr_mode(addr_mode),
      .dev_error(dev_error), .dev_status(dev_status), .dev_rdata(dev_rdata),
      .phy_ready_evt(evt), .phy_change_evt(evt), .pio_valid_r(), .pio_write_r(),
      .pio_wdata_r(), .pio_read_r(), .cmd_start_r(cmd_start_r), .cmd_code_r(),
      .cmd_features_r(feat), .cmd_count_r(cnt), .cmd_sector_r(sect),
      .phy_ready_int_r(rdy_int), .phy_change_int_r(chg_int));
   task end_sim;
      begin
         $display("compared %0d mismatches %0d", n_compared, err_count);
         if (err_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d, input wd);
      begin
         @(posedge clock);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         reg_wide <= wd;
         @(posedge clock);
         reg_wr <= 1'b0;
         #1;
      end
   endtask
   // Holds the data-port spacing so no access lands while a split is busy.
   task rd(input [7:0] a, input wd);
      integer k;
      begin
         @(posedge clock);
         reg_rd <= 1'b1;
         reg_addr <= a;
         reg_wide <= wd;
         #1 w = dev_rdata;
         @(posedge clock);
         reg_rd <= 1'b0;
         #1 k = 0;
         while (reg_rvalid_r !== 1'b1 && k < 8) begin
            @(posedge clock);
            #1 k = k + 1;
         end
         if (k == 8) begin
            err_count = err_count + 1;
            end_sim;
         end
         q = reg_rdata_r;
         repeat (2) @(posedge clock);
      end
   endtask
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      {reset_n, reg_wr, reg_rd, reg_wide, evt} = 5'h00;
      {reg_addr, dev_status, dev_error, reg_wdata, addr_mode} = 58'h0;
      err_count = 0;
      n_compared = 0;
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      rd(8'h08, 1'b0);
      chk(q, 32'h0);
      rd(8'h0c, 1'b0);
      chk(q, 32'h0);
      rd(8'h40, 1'b0);
      chk(q, 32'h0);
      $display("test reset done");
      wr(8'h04, 32'hf00d, 1'b0);
      wr(8'h08, 32'hab12, 1'b0);
      wr(8'h0c, 32'h7e55, 1'b0);
      rd(8'h08, 1'b0);
      chk(q, 32'hab12);
      rd(8'h0c, 1'b0);
      chk(q, 32'h7e55);
      rd(8'h30, 1'b0);
      chk(q, 32'h0);
      rd(8'h04, 1'b0);
      chk(q, 32'h0);
      dev_status <= 8'h01;
      dev_error <= 8'h5a;
      rd(8'h04, 1'b0);
      chk(q, 32'h5a);
      dev_error <= 8'ha5;
      rd(8'h04, 1'b0);
      chk(q, 32'ha5);
      $display("test params done");
      for (i = 0; i < 3; i = i + 1) begin
         @(posedge clock);
         addr_mode <= i[1:0];
         wr(8'h1c, 32'hc8, 1'b0);
         chk({31'h0, cmd_start_r}, 32'h1);
         chk({16'h0, cnt}, (i == 2) ? 32'hab12 : 32'h12);
         chk({feat, sect}, 32'hf00d7e55);
      end
      $display("test command done");
      wr(8'h00, 32'hbeef1234, 1'b1);
      wr(8'h00, 32'h5678abcd, 1'b1);
      repeat (2) @(posedge clock);
      wr(8'h00, 32'hc0de, 1'b0);
      repeat (2) @(posedge clock);
      rd(8'h00, 1'b1);
      chk(q, {w + 16'h2, w + 16'h1});
      rd(8'h00, 1'b0);
      chk(q, {16'h0, w + 16'h1});
      $display("test data done");
      for (i = 0; i < 4; i = i + 1) begin
         wr(8'h40, i, 1'b0);
         @(posedge clock);
         evt <= 1'b1;
         @(posedge clock);
         evt <= 1'b0;
         #1 chk({30'h0, rdy_int, chg_int}, i);
      end
      $display("test mask done");
      end_sim;
   end
endmodule

/* hdl/data_port_split.v */
/*
 Splits one host data-port access, 16 or 32 bits wide, into 16-bit transfers
 toward the device side. Assumes the device side takes one word per cycle.
*/
`timescale 1ns/1ps
`include "taskfile_regs.vh"

module data_port_split (
   input  wire        clock,
   input  wire        reset_n,
   input  wire        start,
   input  wire        wide,
   input  wire        write,
   input  wire [31:0] wdata,
   output reg         xfer_valid_r,
   output reg         xfer_write_r,
   output reg  [15:0] xfer_wdata_r,
   output reg         second_r,
   output reg         busy_r
);

   reg        pend_r;
   reg [15:0] hi_r;

   // The upper half follows the lower half directly in the next cycle.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         xfer_valid_r <= 1'b0;
         xfer_write_r <= 1'b0;
         xfer_wdata_r <= `RST_WORD16;
         second_r     <= 1'b0;
         busy_r       <= 1'b0;
         pend_r       <= 1'b0;
         hi_r         <= `RST_WORD16;
      end else if (pend_r) begin
         xfer_valid_r <= 1'b1;
         xfer_wdata_r <= hi_r;
         second_r     <= 1'b1;
         pend_r       <= 1'b0;
         busy_r       <= 1'b0;
      end else if (start) begin
         xfer_valid_r <= 1'b1;
         xfer_write_r <= write;
         xfer_wdata_r <= wdata[15:0];
         second_r     <= 1'b0;
         pend_r       <= wide;
         busy_r       <= wide;
         hi_r         <= wdata[31:16];
      end else begin
         xfer_valid_r <= 1'b0;
         second_r     <= 1'b0;
      end
   end

endmodule

/* hdl/sata_port_taskfile_regs.v */
/*
 Per-port command block register bank for direct port access mode: data port,
 error, features, sector count, sector number, command launch and interrupt
 mask. Assumes a simple synchronous register port with one-cycle strobes and
 a device-side engine that supplies read data words, error and status.
 A register read issued while a data-port read is still in flight is not
 answered, so the host waits for each data-port answer before the next read.
*/
// Contract
// - Mask bit 1 gates the link-ready interrupt; reset 0 masks it.
// - Mask bit 0 gates the link state-change interrupt; reset 0 masks it.
// - A 16-bit read/write data port moves PIO data words.
// - A 32-bit data port access becomes two back-to-back 16-bit transfers.
// - An 8-bit read-only error register holds current command error status.
// - Error contents are valid while the status error flag is set.
// - A 16-bit features register holds the next command's parameter.
// - A 16-bit read/write sector count register holds the transfer count.
// - For CHS or 28-bit addressing only the low count byte is used.
// - For 48-bit addressing the full 16-bit count is used.
// - A 16-bit read/write sector number register holds an address parameter.
`timescale 1ns/1ps
`include "taskfile_regs.vh"

module sata_port_taskfile_regs (
   input  wire        clock,
   input  wire        reset_n,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [7:0]  reg_addr,
   input  wire        reg_wide,
   input  wire [31:0] reg_wdata,
   output reg  [31:0] reg_rdata_r,
   output reg         reg_rvalid_r,
   input  wire [1:0]  addr_mode,
   input  wire [7:0]  dev_error,
   input  wire [7:0]  dev_status,
   input  wire [15:0] dev_rdata,
   input  wire        phy_ready_evt,
   input  wire        phy_change_evt,
   output reg         pio_valid_r,
   output reg         pio_write_r,
   output reg  [15:0] pio_wdata_r,
   output reg         pio_read_r,
   output reg         cmd_start_r,
   output reg  [7:0]  cmd_code_r,
   output reg  [15:0] cmd_features_r,
   output reg  [15:0] cmd_count_r,
   output reg  [15:0] cmd_sector_r,
   output reg         phy_ready_int_r,
   output reg         phy_change_int_r
);

   reg [15:0] features_r;
   reg [15:0] sect_count_r;
   reg [15:0] sect_number_r;
   reg [1:0]  int_mask_r;
   reg [15:0] rd_lo_r;
   reg        rd_wide_r;
   reg [31:0] rd_word_nxt;
   reg        rd_valid_nxt;

   wire        sp_valid;
   wire        sp_write;
   wire [15:0] sp_wdata;
   wire        sp_second;
   wire        sp_busy;

   wire data_hit = (reg_addr == `OFF_DATA);
   // A data-port access in the cycle after a wide one is dropped, not queued.
   wire data_acc = data_hit && (reg_wr || reg_rd) && !sp_busy;
   wire cmd_hit  = reg_wr && (reg_addr == `OFF_COMMAND);
   // Error contents mean nothing unless the status error flag is set.
   wire [7:0] err_view = dev_status[`STATUS_ERR_BIT] ? dev_error : `RST_BYTE8;

   // Effective count depends on the addressing form.
   function [15:0] eff_count;
      input [1:0]  mode;
      input [15:0] raw;
      begin
         case (mode)
            `ADDR_LBA48: eff_count = raw;
            `ADDR_CHS:   eff_count = {8'h00, raw[7:0]};
            `ADDR_LBA28: eff_count = {8'h00, raw[7:0]};
            default:     eff_count = {8'h00, raw[7:0]};
         endcase
      end
   endfunction

   // The splitter turns each data-port access into 16-bit device transfers.
   data_port_split u_split (
      .clock        (clock),
      .reset_n      (reset_n),
      .start        (data_acc),
      .wide         (reg_wide),
      .write        (reg_wr),
      .wdata        (reg_wdata),
      .xfer_valid_r (sp_valid),
      .xfer_write_r (sp_write),
      .xfer_wdata_r (sp_wdata),
      .second_r     (sp_second),
      .busy_r       (sp_busy)
   );

   // Parameter registers hold plain values until the host rewrites them.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         features_r    <= `RST_WORD16;
         sect_count_r  <= `RST_WORD16;
         sect_number_r <= `RST_WORD16;
         int_mask_r    <= `RST_MASK2;
      end else if (reg_wr) begin
         case (reg_addr)
            `OFF_FEATURES:    features_r    <= reg_wdata[15:0];
            `OFF_SECT_COUNT:  sect_count_r  <= reg_wdata[15:0];
            `OFF_SECT_NUMBER: sect_number_r <= reg_wdata[15:0];
            `OFF_INT_MASK:
               int_mask_r <= reg_wdata[`MASK_PHY_READY:`MASK_PHY_CHANGE];
            default: ;
         endcase
      end
   end

   // Parameters are snapshotted at the command write, so a host that starts
   // loading the next command early cannot disturb the one just launched.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cmd_start_r    <= 1'b0;
         cmd_code_r     <= `RST_BYTE8;
         cmd_features_r <= `RST_WORD16;
         cmd_count_r    <= `RST_WORD16;
         cmd_sector_r   <= `RST_WORD16;
      end else begin
         cmd_start_r <= cmd_hit;
         if (cmd_hit) begin
            cmd_code_r     <= reg_wdata[7:0];
            cmd_features_r <= features_r;
            cmd_count_r    <= eff_count(addr_mode, sect_count_r);
            cmd_sector_r   <= sect_number_r;
         end
      end
   end

   // Interrupt outputs are gated events, not sticky: a consumer that must
   // remember one has to latch it itself.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         phy_ready_int_r  <= 1'b0;
         phy_change_int_r <= 1'b0;
      end else begin
         phy_ready_int_r  <= phy_ready_evt && int_mask_r[`MASK_PHY_READY];
         phy_change_int_r <= phy_change_evt && int_mask_r[`MASK_PHY_CHANGE];
      end
   end

   // Outgoing PIO transfers mirror the splitter one cycle later.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pio_valid_r <= 1'b0;
         pio_write_r <= 1'b0;
         pio_wdata_r <= `RST_WORD16;
         pio_read_r  <= 1'b0;
      end else begin
         pio_valid_r <= sp_valid;
         pio_write_r <= sp_write;
         pio_wdata_r <= sp_wdata;
         pio_read_r  <= sp_valid && !sp_write;
      end
   end

   // A wide read parks its low word until the high word arrives.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rd_lo_r   <= `RST_WORD16;
         rd_wide_r <= 1'b0;
      end else begin
         if (data_acc && reg_rd)
            rd_wide_r <= reg_wide;
         if (sp_valid && !sp_write && !sp_second && rd_wide_r)
            rd_lo_r <= dev_rdata;
      end
   end

   // Next read answer. A data-port word from the splitter takes priority over
   // a register read in the same cycle.
   always @* begin
      rd_word_nxt  = reg_rdata_r;
      rd_valid_nxt = 1'b0;
      if (sp_valid && !sp_write) begin
         if (sp_second) begin
            rd_word_nxt  = {dev_rdata, rd_lo_r};
            rd_valid_nxt = 1'b1;
         end else if (!rd_wide_r) begin
            rd_word_nxt  = {16'h0000, dev_rdata};
            rd_valid_nxt = 1'b1;
         end
      end else if (reg_rd && !data_hit) begin
         rd_valid_nxt = 1'b1;
         case (reg_addr)
            `OFF_ERROR:       rd_word_nxt = {24'h000000, err_view};
            `OFF_SECT_COUNT:  rd_word_nxt = {16'h0000, sect_count_r};
            `OFF_SECT_NUMBER: rd_word_nxt = {16'h0000, sect_number_r};
            `OFF_STATUS:      rd_word_nxt = {24'h000000, dev_status};
            `OFF_INT_MASK:    rd_word_nxt = {30'h0000000, int_mask_r};
            default:          rd_word_nxt = `RST_WORD32;
         endcase
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata_r  <= `RST_WORD32;
         reg_rvalid_r <= 1'b0;
      end else begin
         reg_rdata_r  <= rd_word_nxt;
         reg_rvalid_r <= rd_valid_nxt;
      end
   end

endmodule

/* hdl/taskfile_regs.vh */
/*
 Register offsets, field positions and reset values of the per-port command block
 register bank. Assumes inclusion by the bank and its data-port splitter only.
*/
`ifndef TASKFILE_REGS_VH
`define TASKFILE_REGS_VH

`define OFF_DATA        8'h00
`define OFF_ERROR       8'h04
`define OFF_FEATURES    8'h04
`define OFF_SECT_COUNT  8'h08
`define OFF_SECT_NUMBER 8'h0c
`define OFF_COMMAND     8'h1c
`define OFF_STATUS      8'h1c
`define OFF_INT_MASK    8'h40

`define MASK_PHY_CHANGE 0
`define MASK_PHY_READY  1
`define STATUS_ERR_BIT  0

`define RST_WORD16      16'h0000
`define RST_WORD32      32'h0000_0000
`define RST_BYTE8       8'h00
`define RST_MASK2       2'h0

`define ADDR_CHS        2'h0
`define ADDR_LBA28      2'h1
`define ADDR_LBA48      2'h2

`endif
